// ===== logic/gcr_busy_timer.sv
// down counter that times how long a command keeps the register occupied
`timescale 1ns/10ps
`default_nettype none
module gcr_busy_timer #(
  parameter int W = 24
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         ext_busy,
  output logic              done
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } gcr_tmr_t;
  gcr_tmr_t s_q;
  gcr_tmr_t s_d;

  // reload wins over counting; an external busy holds the count
  always_comb
  begin
    s_d = s_q;
    if (load)
      s_d.cnt = load_val;
    else if (s_q.cnt != '0 && !ext_busy)
      s_d.cnt = s_q.cnt - W'(1);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0;
    else if (clk_en)
      s_q <= s_d;
  end

  assign done = (s_q.cnt == '0) && !ext_busy && !load;
endmodule // gcr_busy_timer
`default_nettype wire

// ===== logic/gcr_command_register.sv
// gyro command register: decode, occupied tracking and operation strobes
//
// Functional notes
// - 8-bit write-only command register at 0x7E, resets to 0x00.
// - writes while busy are dropped, except soft reset 0xB6.
// - a dropped write sets the drop error flag in register 0x02.
// - suspend to normal or fast start-up holds busy up to 80 ms.
// - 0x03 starts fast offset calibration, results go to offsets.
// - codes 0001_01nn set gyro power mode, nn as status field.
// - 0x10 temporary suspend, 0x11 temporary normal, needed before nvm.
// - 0x14 suspend, 0x15 normal, 0x17 fast start-up; 0x16 reserved.
// - 0xA0 copies nvm-backed registers into nvm.
// - 0xB0 flushes buffer, leaves buffer configuration untouched.
// - 0xB6 triggers full reset and reboot, settings reload.
// - undefined codes are ignored.
// - register works in every power mode, suspend included.
`timescale 1ns/10ps
`default_nettype none
`include "gcr_consts.svh"
module gcr_command_register #(
  parameter int STARTUP_CYC = `GCR_STARTUP_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       err_rd,
  input  wire logic       op_busy,
  output logic            cmd_busy,
  output logic            drop_cmd_err,
  output logic            foc_start,
  output logic            pmu_set,
  output logic [1:0]      pmu_mode,
  output logic            pmu_temp,
  output logic            nvm_prog,
  output logic            buf_flush,
  output logic            soft_reset
);
  typedef struct packed {
    gcr_pkg::gcr_state_t st;
    logic [7:0]          cmd;
    logic                drop_err;
    logic                foc;
    logic                pmu;
    logic [1:0]          mode;
    logic [1:0]          cur_mode;
    logic                temp;
    logic                nvm;
    logic                flush;
    logic                srst;
    logic                busy;
  } gcr_state_s_t;

  gcr_state_s_t s_q;
  gcr_state_s_t s_d;
  logic         tmr_load;
  logic [`GCR_CNT_W-1:0] tmr_val;
  logic         tmr_done;
  logic         cmd_wr;
  logic         busy;

  gcr_busy_timer #(.W(`GCR_CNT_W)) u_timer (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .load     (tmr_load),
    .load_val (tmr_val),
    .ext_busy (op_busy),
    .done     (tmr_done)
  );

  assign cmd_wr = wr_en && (wr_addr == `GCR_CMD_ADDR);
  assign busy   = s_q.busy;

  // decode; strobes are one cycle wide, busy lasts until the timer ends
  always_comb
  begin
    s_d       = s_q;
    s_d.foc   = 1'b0;
    s_d.pmu   = 1'b0;
    s_d.nvm   = 1'b0;
    s_d.flush = 1'b0;
    s_d.srst  = 1'b0;
    tmr_load  = 1'b0;
    tmr_val   = `GCR_CNT_W'(1);
    // reading the error register clears the flag, a new drop wins
    if (err_rd && wr_addr == `GCR_ERR_ADDR)
      s_d.drop_err = 1'b0;
    case (s_q.st)
      gcr_pkg::GCR_BUSY:
      begin
        s_d.st = gcr_pkg::GCR_WAIT;
      end
      gcr_pkg::GCR_WAIT:
      begin
        if (tmr_done)
          s_d.st = gcr_pkg::GCR_IDLE;
      end
      gcr_pkg::GCR_RESET:
      begin
        // reboot reload of settings is done by the system on the strobe
        if (tmr_done)
        begin
          s_d          = '0;
          s_d.st       = gcr_pkg::GCR_IDLE;
        end
      end
      default:
      begin
        s_d.st = gcr_pkg::GCR_IDLE;
      end
    endcase
    // no power-mode gating: accepted in suspend too
    if (cmd_wr)
    begin
      if (wr_data == `GCR_CODE_SRST)
      begin
        s_d.cmd  = wr_data;
        s_d.srst = 1'b1;
        s_d.st   = gcr_pkg::GCR_RESET;
        tmr_load = 1'b1;
      end
      else if (busy)
        s_d.drop_err = 1'b1;
      else
      begin
        s_d.cmd = wr_data;
        if (wr_data == `GCR_CODE_FOC)
        begin
          s_d.foc = 1'b1;
          s_d.st  = gcr_pkg::GCR_BUSY;
          tmr_load = 1'b1;
        end
        else if (wr_data == `GCR_CODE_TMP_SUSP ||
                 wr_data == `GCR_CODE_TMP_NORM)
        begin
          s_d.pmu  = 1'b1;
          s_d.temp = 1'b1;
          s_d.mode = {1'b0, wr_data[0]};
          s_d.st   = gcr_pkg::GCR_BUSY;
          tmr_load = 1'b1;
        end
        else if ((wr_data & `GCR_PMU_MASK) == `GCR_PMU_BASE &&
                 wr_data != `GCR_CODE_RES)
        begin
          s_d.pmu      = 1'b1;
          s_d.temp     = 1'b0;
          s_d.mode     = wr_data[1:0];
          s_d.cur_mode = wr_data[1:0];
          s_d.st       = gcr_pkg::GCR_BUSY;
          tmr_load     = 1'b1;
          // waking from suspend takes the long start-up time
          if (s_q.cur_mode == `GCR_PMU_SUSP &&
              wr_data[1:0] != `GCR_PMU_SUSP)
            tmr_val = `GCR_CNT_W'(STARTUP_CYC);
        end
        else if (wr_data == `GCR_CODE_PROG_NVM)
        begin
          s_d.nvm  = 1'b1;
          s_d.st   = gcr_pkg::GCR_BUSY;
          tmr_load = 1'b1;
        end
        else if (wr_data == `GCR_CODE_FLUSH)
        begin
          s_d.flush = 1'b1;
          s_d.st    = gcr_pkg::GCR_BUSY;
          tmr_load  = 1'b1;
        end
        // any other code leaves everything as is
        else
          s_d.cmd = s_q.cmd;
      end
    end
    // busy has its own flop so the port needs no state decode
    s_d.busy = (s_d.st != gcr_pkg::GCR_IDLE);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q     <= '0;
      s_q.st  <= gcr_pkg::GCR_IDLE;
      s_q.cmd <= `GCR_CMD_RESET;
    end
    else if (clk_en)
      s_q <= s_d;
  end

  // outputs straight from state flops
  assign cmd_busy     = s_q.busy;
  assign drop_cmd_err = s_q.drop_err;
  assign foc_start    = s_q.foc;
  assign pmu_set      = s_q.pmu;
  assign pmu_mode     = s_q.mode;
  assign pmu_temp     = s_q.temp;
  assign nvm_prog     = s_q.nvm;
  assign buf_flush    = s_q.flush;
  assign soft_reset   = s_q.srst;
endmodule // gcr_command_register
`default_nettype wire

// ===== shared/gcr_consts.svh
// constants of the gyro command register block
`ifndef GCR_CONSTS_SVH
`define GCR_CONSTS_SVH
`define GCR_CMD_ADDR      7'h7E
`define GCR_ERR_ADDR      7'h02
`define GCR_CMD_RESET     8'h00
`define GCR_CODE_FOC      8'h03
`define GCR_CODE_TMP_SUSP 8'h10
`define GCR_CODE_TMP_NORM 8'h11
`define GCR_CODE_SUSP     8'h14
`define GCR_CODE_NORM     8'h15
`define GCR_CODE_RES      8'h16
`define GCR_CODE_FSUP     8'h17
`define GCR_CODE_PROG_NVM 8'hA0
`define GCR_CODE_FLUSH    8'hB0
`define GCR_CODE_SRST     8'hB6
`define GCR_PMU_MASK      8'hFC
`define GCR_PMU_BASE      8'h14
`define GCR_DROP_BIT      6
`define GCR_PMU_SUSP      2'h0
`define GCR_PMU_NORM      2'h1
`define GCR_PMU_FSUP      2'h3
`define GCR_STARTUP_MS    80
`define GCR_CLK_KHZ       100000
`define GCR_STARTUP_CYC   (`GCR_STARTUP_MS * `GCR_CLK_KHZ)
`define GCR_CNT_W         24
`endif

// ===== shared/gcr_pkg.sv
// types of the gyro command register block
`default_nettype none
package gcr_pkg;
  typedef enum logic [3:0] {
    GCR_IDLE  = 4'b0001,
    GCR_BUSY  = 4'b0010,
    GCR_WAIT  = 4'b0100,
    GCR_RESET = 4'b1000
  } gcr_state_t;
endpackage
`default_nettype wire

// ===== verif/gcr_command_register_sva.sv
// checker of the command register port behaviour
`timescale 1ns/10ps
`default_nettype none
module gcr_command_register_sva (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       clk_en,
  input wire logic       wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       cmd_busy,
  input wire logic       drop_cmd_err,
  input wire logic       foc_start,
  input wire logic       pmu_set,
  input wire logic [1:0] pmu_mode,
  input wire logic       nvm_prog,
  input wire logic       buf_flush,
  input wire logic       soft_reset
);
  // accepted and dropped writes to the command register
  wire logic       acc = clk_en && wr_en && wr_addr == 7'h7E;
  wire logic       go  = acc && !cmd_busy;
  wire logic       drp = acc && cmd_busy && wr_data != 8'hB6;
  wire logic [1:0] nn  = wr_data[1:0];
  wire logic       any = foc_start || pmu_set || nvm_prog || buf_flush;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_foc_strobe: assert property
    (go && wr_data == 8'h03 |=> foc_start)
    else $error("calibration strobe missing");
  chk_pmu_mode: assert property
    (go && wr_data inside {8'h14, 8'h15, 8'h17}
    |=> pmu_set && pmu_mode == $past(nn))
    else $error("power mode not set");
  chk_nvm_strobe: assert property
    (go && wr_data == 8'hA0 |=> nvm_prog)
    else $error("nvm strobe missing");
  chk_flush_strobe: assert property
    (go && wr_data == 8'hB0 |=> buf_flush)
    else $error("flush strobe missing");
  chk_srst_taken: assert property
    (acc && wr_data == 8'hB6 |=> soft_reset)
    else $error("soft reset not taken");
  chk_drop_quiet: assert property (drp |=> !any)
    else $error("busy write acted on");
  chk_drop_flag: assert property (drp |=> drop_cmd_err)
    else $error("drop flag not set");
  chk_undef_code: assert property
    (go && wr_data == 8'h16 |=> !cmd_busy && !any)
    else $error("reserved code acted on");
  // the shortest command holds busy for two cycles: write edge and timer
  chk_busy_hold: assert property
    ($rose(cmd_busy) |-> cmd_busy [*2])
    else $error("busy too short");
  cover property (drp);
  cover property (acc && cmd_busy && wr_data == 8'hB6);
  cover property (go && wr_data == 8'h15);
endmodule // gcr_command_register_sva
bind gcr_command_register gcr_command_register_sva u_sva (
  .ref_clk      (ref_clk),
  .rst_b        (rst_b),
  .clk_en       (clk_en),
  .wr_en        (wr_en),
  .wr_addr      (wr_addr),
  .wr_data      (wr_data),
  .cmd_busy     (cmd_busy),
  .drop_cmd_err (drop_cmd_err),
  .foc_start    (foc_start),
  .pmu_set      (pmu_set),
  .pmu_mode     (pmu_mode),
  .nvm_prog     (nvm_prog),
  .buf_flush    (buf_flush),
  .soft_reset   (soft_reset)
);
`default_nettype wire

// ===== verif/gcr_op_model.sv
// model of the operation engine that holds op_busy while it works
`timescale 1ns/10ps
`default_nettype none
module gcr_op_model (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       start,
  input wire logic [3:0] len,
  output logic           op_busy
);
  logic [3:0] cnt_q;
  assign op_busy = cnt_q != 4'h0;
  // len of zero answers promptly, larger values stall the register
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      cnt_q <= 4'h0;
    else if (start)
      cnt_q <= len;
    else if (op_busy)
      cnt_q <= cnt_q - 4'h1;
endmodule // gcr_op_model
`default_nettype wire

// ===== verif/tb.sv
// testbench of the gyro command register
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int SC = 20;
  localparam int SU = 3; // scaled system start-up wait after soft reset
  logic       ref_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
  logic       wr_en = 1'b0, err_rd = 1'b0;
  logic [6:0] wr_addr = 7'h7E;
  logic [7:0] wr_data = 8'h00;
  logic [3:0] len = 4'h0;
  logic       op_busy, cmd_busy, drop_cmd_err, foc_start, pmu_set;
  logic       pmu_temp, nvm_prog, buf_flush, soft_reset;
  logic [1:0] pmu_mode;
  int         num_errors = 0, n_tests = 0, n, i;
  // temporary normal is issued before nvm programming, as a host must
  logic [7:0] codes [7] = '{8'h03, 8'h11, 8'hA0, 8'hB0, 8'h14, 8'h17,
                            8'h10};
  logic [7:0] exps [7]  = '{8'h10, 8'h28, 8'h24, 8'h22, 8'h08, 8'h08,
                            8'h28};
  wire logic [4:0] strb = {foc_start, pmu_set, nvm_prog, buf_flush, soft_reset};
  gcr_command_register #(
    .STARTUP_CYC (SC)
  ) u_gcr_command_register (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .clk_en       (clk_en),
    .wr_en        (wr_en),
    .wr_addr      (wr_addr),
    .wr_data      (wr_data),
    .err_rd       (err_rd),
    .op_busy      (op_busy),
    .cmd_busy     (cmd_busy),
    .drop_cmd_err (drop_cmd_err),
    .foc_start    (foc_start),
    .pmu_set      (pmu_set),
    .pmu_mode     (pmu_mode),
    .pmu_temp     (pmu_temp),
    .nvm_prog     (nvm_prog),
    .buf_flush    (buf_flush),
    .soft_reset   (soft_reset)
  );
  gcr_op_model u_gcr_op_model (.ref_clk(ref_clk), .rst_b(rst_b),
    .start(foc_start | nvm_prog | buf_flush), .len(len), .op_busy(op_busy));
  initial
    forever #5 ref_clk = ~ref_clk;
  task automatic test_done;
    $display("errors %0d tests %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one write, then sample the registered answer a step after its edge
  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    wr_addr <= 7'h7E;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  // bounded wait for the register to free up
  task automatic idle;
    n = 0;
    while (cmd_busy !== 1'b0 && n < 300)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (cmd_busy !== 1'b0)
    begin
      num_errors++;
      test_done;
    end
  endtask
  initial
  begin
    #200000;
    num_errors++;
    test_done;
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk({pmu_mode, strb, cmd_busy}, 8'h00);
    wr(8'h15);
    chk({pmu_mode, strb, cmd_busy}, 8'h51);
    wr(8'h03);
    chk({2'h0, strb, drop_cmd_err}, 8'h01);
    idle;
    chk({7'h0, n >= SC - 2 && n <= SC + 2}, 8'h01);
    @(posedge ref_clk);
    err_rd <= 1'b1;
    wr_addr <= 7'h02;
    @(posedge ref_clk);
    err_rd <= 1'b0;
    #1;
    chk({7'h0, drop_cmd_err}, 8'h00);
    // each defined code but 0x15 and 0xB6 once, engine length stepping up by two per code
    for (i = 0; i < 7; i++)
    begin
      len <= 4'(i * 2);
      wr(codes[i]);
      chk({2'h0, pmu_temp, strb}, exps[i]);
      idle;
    end
    wr(8'h16);
    chk({2'h0, strb, cmd_busy}, 8'h00);
    wr(8'h42);
    chk({2'h0, strb, cmd_busy}, 8'h00);
    wr(8'h14);
    idle;
    wr(8'h15);
    wr(8'h03);
    chk({7'h0, drop_cmd_err}, 8'h01);
    wr(8'hB6);
    chk({2'h0, strb, cmd_busy}, 8'h03);
    idle;
    chk({5'h0, pmu_mode, drop_cmd_err}, 8'h00);
    // restart after soft reset: start-up wait, then the long wake
    repeat (SU) @(posedge ref_clk);
    wr(8'h15);
    idle;
    chk({7'h0, n >= SC - 2 && n <= SC + 2}, 8'h01);
    wr(8'h03);
    chk({2'h0, strb, cmd_busy}, 8'h21);
    // low clock enable keeps busy although the engine has finished
    @(posedge ref_clk);
    clk_en <= 1'b0;
    repeat (15) @(posedge ref_clk);
    #1;
    chk({2'h0, strb, cmd_busy}, 8'h01);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    idle;
    test_done;
  end
endmodule // tb
`default_nettype wire
